//--- sep_pkg.sv
// Shared constants for the serial EEPROM protect, erase and power-down logic.
// Assumes a 100 MHz system clock; every delay is derived from it here.
package sep_pkg;

  localparam int CLK_MHZ = 100;
  localparam int CNT_W = 24;
  localparam int ADDR_W = 16;

  // Opcodes
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OP_PAGE_ERASE_CMD = 8'h42;
  localparam logic [7:0] OP_SECTOR_ERASE_CMD = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_SIGNATURE_READ_RELEASE_CMD = 8'hab;
  localparam logic [7:0] OP_DEEP_SLEEP_CMD = 8'hb9;

  // Status byte layout
  localparam int SR_PROT_PIN_EN = 7;
  localparam int SR_BP_HIGH = 3;
  localparam int SR_BP_LOW = 2;
  localparam int SR_WEL = 1;
  localparam int SR_BUSY = 0;

  // Protected range bases per protection code
  localparam logic [15:0] PROT_QUARTER_BASE = 16'hc000;
  localparam logic [15:0] PROT_HALF_BASE = 16'h8000;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_OFS_W = $clog2(PAGE_BYTES);
  localparam int SECTOR_OFS_W = 14;

  // Self-timed cycle lengths, in microseconds, and in clock cycles
  localparam int T_WRITE_US = 5000;
  localparam int T_STATUS_WRITE_US = 5000;
  localparam int T_PAGE_ERASE_US = 5000;
  localparam int T_SECTOR_ERASE_US = 10000;
  localparam int T_CHIP_ERASE_US = 10000;
  localparam int WRITE_CYC = T_WRITE_US * CLK_MHZ;
  localparam int STATUS_WRITE_CYC = T_STATUS_WRITE_US * CLK_MHZ;
  localparam int PAGE_ERASE_CYC = T_PAGE_ERASE_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYC = T_SECTOR_ERASE_US * CLK_MHZ;
  localparam int CHIP_ERASE_CYC = T_CHIP_ERASE_US * CLK_MHZ;

  // Power state delays, in nanoseconds, rounded up to whole cycles
  localparam int SLEEP_SETTLE_DELAY_NS = 3000;
  localparam int WAKE_RELEASE_DELAY_NS = 3000;
  localparam int SLEEP_SETTLE_CYC = (SLEEP_SETTLE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_RELEASE_CYC = (WAKE_RELEASE_DELAY_NS * CLK_MHZ + 999) / 1000;

  // Kind of internal operation reported on the array port
  localparam logic [2:0] KIND_NONE = 3'h0;
  localparam logic [2:0] KIND_WRITE = 3'h1;
  localparam logic [2:0] KIND_STATUS = 3'h2;
  localparam logic [2:0] KIND_PAGE = 3'h3;
  localparam logic [2:0] KIND_SECTOR = 3'h4;
  localparam logic [2:0] KIND_CHIP = 3'h5;

endpackage

//--- sep_spi_if.sv
// Decoded serial-bus events passed from the receiver to the command core.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface sep_spi_if;
  logic sel;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic at_boundary;
  logic byte_valid;
  logic [7:0] byte_data;
  logic [2:0] byte_idx;
  logic [2:0] bytes_done;
  modport rx (output sel, sck_fall, cs_fall, cs_rise, at_boundary, byte_valid, byte_data,
              byte_idx, bytes_done);
  modport core (input sel, sck_fall, cs_fall, cs_rise, at_boundary, byte_valid, byte_data,
                byte_idx, bytes_done);
endinterface

//--- sep_spi_rx.sv
// Serial receiver: finds clock and select edges and assembles bytes.
// Assumes select, clock and data are already synchronised to clk_i.
`timescale 1ns/1ps
module sep_spi_rx (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  sep_spi_if.rx spi
);
  typedef struct packed {
    logic sck_p;
    logic cs_n_p;
    logic [6:0] sh;
    logic [2:0] bitc;
    logic [2:0] bytec;
    logic vld;
    logic [7:0] data;
    logic [2:0] idx;
  } sep_rx_st_t;

  sep_rx_st_t q;
  sep_rx_st_t d;
  logic rise;

  assign rise = sck_i & ~q.sck_p & ~cs_n_i;

  always_comb begin
    d = q;
    d.sck_p = sck_i;
    d.cs_n_p = cs_n_i;
    d.vld = 1'b0;
    if (cs_n_i) begin
      d.bitc = 3'h0;
      d.bytec = 3'h0;
    end else if (rise) begin
      d.sh = {q.sh[5:0], si_i};
      d.bitc = q.bitc + 3'h1;
      if (q.bitc == 3'h7) begin
        d.vld = 1'b1;
        d.data = {q.sh, si_i};
        d.idx = q.bytec;
        if (q.bytec != 3'h7) begin
          d.bytec = q.bytec + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{sck_p: 1'b0, cs_n_p: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign spi.sel = ~cs_n_i;
  assign spi.sck_fall = ~sck_i & q.sck_p & ~cs_n_i;
  assign spi.cs_fall = ~cs_n_i & q.cs_n_p;
  assign spi.cs_rise = cs_n_i & ~q.cs_n_p;
  assign spi.at_boundary = (q.bitc == 3'h0);
  assign spi.byte_valid = q.vld;
  assign spi.byte_data = q.data;
  assign spi.byte_idx = q.idx;
  assign spi.bytes_done = q.bytec;
endmodule

//--- sep_cycle_timer.sv
// Down-counter for self-timed cycles and power state delays.
// Assumes load is at least one whenever start is pulsed.
`timescale 1ns/1ps
module sep_cycle_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [sep_pkg::CNT_W-1:0] load_i,
  output logic busy_o,
  output logic done_o
);
  typedef struct packed {
    logic busy;
    logic [sep_pkg::CNT_W-1:0] cnt;
  } sep_tmr_st_t;

  sep_tmr_st_t q;
  sep_tmr_st_t d;

  always_comb begin
    d = q;
    if (start_i) begin
      d.busy = 1'b1;
      d.cnt = load_i;
    end else if (q.busy) begin
      d.cnt = q.cnt - 1'b1;
      if (q.cnt == 1) begin
        d.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy_o = q.busy;
  assign done_o = q.busy & (q.cnt == 1);
endmodule

//--- sep_top.sv
// Command core of a serial EEPROM: status protection, erase and deep power-down.
// Assumes the array itself sits outside and acts on op_start_o / wr_data_valid_o.
`timescale 1ns/1ps
module sep_top #(
  parameter int WRITE_CYC = sep_pkg::WRITE_CYC,
  parameter int STATUS_WRITE_CYC = sep_pkg::STATUS_WRITE_CYC,
  parameter int PAGE_ERASE_CYC = sep_pkg::PAGE_ERASE_CYC,
  parameter int SECTOR_ERASE_CYC = sep_pkg::SECTOR_ERASE_CYC,
  parameter int CHIP_ERASE_CYC = sep_pkg::CHIP_ERASE_CYC,
  // Arbitrary signature value
  parameter logic [7:0] SIGNATURE = 8'h5a
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic [7:0] nv_status_i,
  output logic so_o,
  output logic so_oe_o,
  output logic busy_flag_o,
  output logic write_enable_latch_o,
  output logic block_protect_high_o,
  output logic block_protect_low_o,
  output logic protect_pin_enable_bit_o,
  output logic deep_sleep_o,
  output logic op_start_o,
  output logic [2:0] op_kind_o,
  output logic [15:0] op_addr_o,
  output logic op_done_o,
  output logic [7:0] wr_data_o,
  output logic wr_data_valid_o
);
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic [1:0] rst_ff;
  logic rst_n;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic wp_n_s;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  // Select and protect idle high, clock idles low: no false edge is seen after reset
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 4'hc;
      pin_s2 <= 4'hc;
    end else begin
      pin_s1 <= {wp_n_i, cs_n_i, sck_i, si_i};
      pin_s2 <= pin_s1;
    end
  end
  assign si_s = pin_s2[0];
  assign sck_s = pin_s2[1];
  assign cs_n_s = pin_s2[2];
  assign wp_n_s = pin_s2[3];

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Receiver and timers
  sep_spi_if spi ();

  sep_spi_rx u_rx (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n),
    .sck_i(sck_s),
    .cs_n_i(cs_n_s),
    .si_i(si_s),
    .spi(spi)
  );

  logic t1_start;
  logic [sep_pkg::CNT_W-1:0] t1_load;
  logic t1_busy;
  logic t1_done;
  logic t2_start;
  logic [sep_pkg::CNT_W-1:0] t2_load;
  logic t2_done;

  sep_cycle_timer u_prog_tmr (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n),
    .start_i(t1_start),
    .load_i(t1_load),
    .busy_o(t1_busy),
    .done_o(t1_done)
  );

  sep_cycle_timer u_pwr_tmr (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n),
    .start_i(t2_start),
    .load_i(t2_load),
    .busy_o(),
    .done_o(t2_done)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Core state
  typedef enum logic [2:0] {
    PW_WAIT_ARM,
    PW_STANDBY,
    PW_SETTLE,
    PW_ASLEEP,
    PW_WAKE
  } sep_pwr_t;

  typedef struct packed {
    sep_pwr_t pwr;
    logic nv_pend;
    logic protect_pin_enable_bit;
    logic [1:0] bp;
    logic write_enable_latch;
    logic [7:0] op;
    logic [15:0] addr;
    logic [7:0] sr_new;
    logic [2:0] run_kind;
    logic out_act;
    logic [7:0] out_sh;
    logic so;
    logic op_start;
    logic [2:0] op_kind;
    logic [15:0] op_addr;
    logic op_done;
    logic [7:0] wr_data;
    logic wr_vld;
  } sep_core_st_t;

  sep_core_st_t q;
  sep_core_st_t d;

  function automatic logic sep_in_prot(input logic [1:0] bp, input logic [15:0] a);
    case (bp)
      2'b00: sep_in_prot = 1'b0;
      2'b01: sep_in_prot = (a >= sep_pkg::PROT_QUARTER_BASE);
      2'b10: sep_in_prot = (a >= sep_pkg::PROT_HALF_BASE);
      default: sep_in_prot = 1'b1;
    endcase
  endfunction

  logic hw_prot;
  logic ready;
  logic asleep;
  logic [7:0] cur_op;
  logic [7:0] status_byte;
  logic [15:0] page_base;
  logic [15:0] sector_base;

  assign hw_prot = q.protect_pin_enable_bit & ~wp_n_s;
  assign ready = (q.pwr == PW_STANDBY) & ~t1_busy;
  assign asleep = (q.pwr == PW_SETTLE) | (q.pwr == PW_ASLEEP);
  assign cur_op = (spi.byte_idx == 3'h0) ? spi.byte_data : q.op;
  assign page_base = {q.addr[15:sep_pkg::PAGE_OFS_W], {sep_pkg::PAGE_OFS_W{1'b0}}};
  assign sector_base = {q.addr[15:sep_pkg::SECTOR_OFS_W], {sep_pkg::SECTOR_OFS_W{1'b0}}};

  always_comb begin
    status_byte = 8'h00;
    status_byte[sep_pkg::SR_PROT_PIN_EN] = q.protect_pin_enable_bit;
    status_byte[sep_pkg::SR_BP_HIGH] = q.bp[1];
    status_byte[sep_pkg::SR_BP_LOW] = q.bp[0];
    status_byte[sep_pkg::SR_WEL] = q.write_enable_latch;
    status_byte[sep_pkg::SR_BUSY] = t1_busy;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    d.op_start = 1'b0;
    d.op_done = 1'b0;
    d.wr_vld = 1'b0;
    t1_start = 1'b0;
    t1_load = '0;
    t2_start = 1'b0;
    t2_load = '0;

    // Nonvolatile bits come back from the cell image after every power-up
    if (q.nv_pend) begin
      d.nv_pend = 1'b0;
      d.protect_pin_enable_bit = nv_status_i[sep_pkg::SR_PROT_PIN_EN];
      d.bp = {nv_status_i[sep_pkg::SR_BP_HIGH], nv_status_i[sep_pkg::SR_BP_LOW]};
    end

    if (!spi.sel) begin
      d.out_act = 1'b0;
      d.so = 1'b0;
    end

    if (spi.cs_fall && q.pwr == PW_WAIT_ARM) begin
      d.pwr = PW_STANDBY;
    end

    // Byte arrivals
    if (spi.byte_valid && q.pwr != PW_WAIT_ARM) begin
      case (spi.byte_idx)
        3'h0: d.op = spi.byte_data;
        3'h1: d.addr[15:8] = spi.byte_data;
        3'h2: d.addr[7:0] = spi.byte_data;
        default: ;
      endcase
      if (cur_op == sep_pkg::OP_STATUS_READ && q.pwr == PW_STANDBY) begin
        d.out_act = 1'b1;
        d.out_sh = status_byte;
      end
      if (cur_op == sep_pkg::OP_SIGNATURE_READ_RELEASE_CMD) begin
        if (spi.byte_idx == 3'h0 && asleep) begin
          d.pwr = PW_WAKE;
          t2_start = 1'b1;
          t2_load = sep_pkg::CNT_W'(sep_pkg::WAKE_RELEASE_CYC);
        end
        if (spi.byte_idx >= 3'h2 && (ready || q.pwr == PW_WAKE)) begin
          d.out_act = 1'b1;
          d.out_sh = SIGNATURE;
        end
      end
      if (cur_op == sep_pkg::OP_WRITE && spi.byte_idx >= 3'h3 && ready) begin
        d.wr_vld = 1'b1;
        d.wr_data = spi.byte_data;
      end
    end

    // Output shifts on the falling serial clock edge
    if (spi.sck_fall && q.out_act) begin
      d.so = q.out_sh[7];
      d.out_sh = {q.out_sh[6:0], 1'b0};
    end

    // Latch, status-write, write, erase and sleep commands execute only on a select rise at a whole-byte boundary
    if (spi.cs_rise && ready && spi.at_boundary) begin
      case (q.op)
        sep_pkg::OP_WRITE_ENABLE_CMD: begin
          if (spi.bytes_done == 3'h1) begin
            d.write_enable_latch = 1'b1;
          end
        end
        sep_pkg::OP_WRITE_DISABLE: begin
          if (spi.bytes_done == 3'h1) begin
            d.write_enable_latch = 1'b0;
          end
        end
        sep_pkg::OP_STATUS_WRITE_CMD: begin
          if (spi.bytes_done == 3'h2 && q.write_enable_latch && !hw_prot) begin
            d.sr_new = q.addr[15:8];
            d.run_kind = sep_pkg::KIND_STATUS;
            t1_start = 1'b1;
            t1_load = sep_pkg::CNT_W'(STATUS_WRITE_CYC);
          end
        end
        sep_pkg::OP_WRITE: begin
          // Array writes ignore the hardware protect pin
          if (spi.bytes_done >= 3'h4 && q.write_enable_latch && !sep_in_prot(q.bp, q.addr)) begin
            d.run_kind = sep_pkg::KIND_WRITE;
            d.op_start = 1'b1;
            d.op_kind = sep_pkg::KIND_WRITE;
            d.op_addr = q.addr;
            t1_start = 1'b1;
            t1_load = sep_pkg::CNT_W'(WRITE_CYC);
          end
        end
        sep_pkg::OP_PAGE_ERASE_CMD: begin
          if (spi.bytes_done == 3'h3 && q.write_enable_latch) begin
            if (sep_in_prot(q.bp, q.addr)) begin
              d.write_enable_latch = 1'b0;
            end else begin
              d.run_kind = sep_pkg::KIND_PAGE;
              d.op_start = 1'b1;
              d.op_kind = sep_pkg::KIND_PAGE;
              d.op_addr = page_base;
              t1_start = 1'b1;
              t1_load = sep_pkg::CNT_W'(PAGE_ERASE_CYC);
            end
          end
        end
        sep_pkg::OP_SECTOR_ERASE_CMD: begin
          if (spi.bytes_done == 3'h3 && q.write_enable_latch) begin
            if (sep_in_prot(q.bp, q.addr)) begin
              d.write_enable_latch = 1'b0;
            end else begin
              d.run_kind = sep_pkg::KIND_SECTOR;
              d.op_start = 1'b1;
              d.op_kind = sep_pkg::KIND_SECTOR;
              d.op_addr = sector_base;
              t1_start = 1'b1;
              t1_load = sep_pkg::CNT_W'(SECTOR_ERASE_CYC);
            end
          end
        end
        sep_pkg::OP_CHIP_ERASE: begin
          if (spi.bytes_done == 3'h1 && q.write_enable_latch) begin
            if (q.bp != 2'b00) begin
              d.write_enable_latch = 1'b0;
            end else begin
              d.run_kind = sep_pkg::KIND_CHIP;
              d.op_start = 1'b1;
              d.op_kind = sep_pkg::KIND_CHIP;
              d.op_addr = 16'h0000;
              t1_start = 1'b1;
              t1_load = sep_pkg::CNT_W'(CHIP_ERASE_CYC);
            end
          end
        end
        sep_pkg::OP_DEEP_SLEEP_CMD: begin
          if (spi.bytes_done == 3'h1) begin
            d.pwr = PW_SETTLE;
            t2_start = 1'b1;
            t2_load = sep_pkg::CNT_W'(sep_pkg::SLEEP_SETTLE_CYC);
          end
        end
        default: ;
      endcase
    end

    // End of a self-timed cycle
    if (t1_done) begin
      d.op_done = 1'b1;
      d.run_kind = sep_pkg::KIND_NONE;
      d.write_enable_latch = 1'b0;
      if (q.run_kind == sep_pkg::KIND_STATUS) begin
        d.protect_pin_enable_bit = q.sr_new[sep_pkg::SR_PROT_PIN_EN];
        d.bp = {q.sr_new[sep_pkg::SR_BP_HIGH], q.sr_new[sep_pkg::SR_BP_LOW]};
      end
    end

    // Power state delays; a wake request outranks a settle expiry in the same cycle
    if (t2_done && !t2_start) begin
      case (q.pwr)
        PW_SETTLE: d.pwr = PW_ASLEEP;
        PW_WAKE: d.pwr = PW_STANDBY;
        default: ;
      endcase
    end
  end

  // Power loss is the reset: sleep and latch both clear, select counts as high
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{pwr: PW_WAIT_ARM, nv_pend: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign so_o = q.so;
  assign so_oe_o = q.out_act & spi.sel;
  assign busy_flag_o = t1_busy;
  assign write_enable_latch_o = q.write_enable_latch;
  assign block_protect_high_o = q.bp[1];
  assign block_protect_low_o = q.bp[0];
  assign protect_pin_enable_bit_o = q.protect_pin_enable_bit;
  assign deep_sleep_o = asleep;
  assign op_start_o = q.op_start;
  assign op_kind_o = q.op_kind;
  assign op_addr_o = q.op_addr;
  assign op_done_o = q.op_done;
  assign wr_data_o = q.wr_data;
  assign wr_data_valid_o = q.wr_vld;
endmodule

//--- sep_top_sva.sv
// Concurrent checks on the command core, watching its top ports only.
// Assumes one clock domain and the active-low reset rstn_i.
`timescale 1ns/1ps
module sep_top_sva (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic so_oe_o,
  input wire logic busy_flag_o,
  input wire logic write_enable_latch_o,
  input wire logic block_protect_high_o,
  input wire logic block_protect_low_o,
  input wire logic deep_sleep_o,
  input wire logic op_start_o,
  input wire logic [2:0] op_kind_o,
  input wire logic [15:0] op_addr_o,
  input wire logic op_done_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  logic [1:0] bp;
  logic hit;
  assign bp = {block_protect_high_o, block_protect_low_o};
  // Address falls in the range guarded by the protection code
  assign hit = (bp == 2'h3) || (bp == 2'h2 && op_addr_o[15]) ||
               (bp == 2'h1 && op_addr_o[15:14] == 2'h3);
  ////////////////////////////////////////////////////////////////////////////
  start_busy_a: assert property (op_start_o |-> busy_flag_o)
    else $error("busy low at cycle launch");
  page_align_a: assert property (op_start_o && op_kind_o == sep_pkg::KIND_PAGE
    |-> op_addr_o[6:0] == 7'h00) else $error("page address not aligned");
  sector_align_a: assert property (op_start_o && op_kind_o == sep_pkg::KIND_SECTOR
    |-> op_addr_o[13:0] == 14'h0000) else $error("sector address not aligned");
  chip_unprot_a: assert property (op_start_o && op_kind_o == sep_pkg::KIND_CHIP
    |-> bp == 2'h0) else $error("chip erase with protection set");
  erase_prot_a: assert property (op_start_o && (op_kind_o == sep_pkg::KIND_PAGE ||
    op_kind_o == sep_pkg::KIND_SECTOR) |-> !hit) else $error("protected erase launched");
  start_latch_a: assert property (op_start_o |-> $past(write_enable_latch_o))
    else $error("cycle launched without latch");
  done_latch_a: assert property (op_done_o |=> !write_enable_latch_o && !busy_flag_o)
    else $error("latch or busy left set after cycle");
  cs_rise_a: assert property ($rose(busy_flag_o) |-> cs_n_i && $past(cs_n_i, 2))
    else $error("cycle launched while selected");
  idle_oe_a: assert property (cs_n_i [*4] |-> !so_oe_o)
    else $error("output driven while deselected");
  sleep_quiet_a: assert property (deep_sleep_o |-> !op_start_o)
    else $error("cycle launched in deep sleep");
  reset_state_a: assert property ($rose(rstn_i) |-> !write_enable_latch_o && !deep_sleep_o)
    else $error("latch or sleep set after reset");
endmodule

bind sep_top sep_top_sva sep_top_sva_i (.clk_sys_i, .rstn_i, .cs_n_i, .so_oe_o, .busy_flag_o,
  .write_enable_latch_o, .block_protect_high_o, .block_protect_low_o, .deep_sleep_o,
  .op_start_o, .op_kind_o, .op_addr_o, .op_done_o);

//--- sep_host_model.sv
// SPI mode 0 host model framing commands for the command core.
// Assumes the bench clock paces it; sck idles low and stops between frames.
`timescale 1ns/1ps
module sep_host_model (
  input wire logic clk_i,
  input wire logic so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic [7:0] rx_o
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    rx_o = 8'h00;
  end
  // Sends the top nbits of bits MSB first; sck half period is 8 clocks
  task automatic send(input logic [31:0] bits, input int nbits);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 31; i > 31 - nbits; i--) begin
      si_o <= bits[i];
      repeat (8) @(posedge clk_i);
      sck_o <= 1'b1;
      rx_o <= {rx_o[6:0], so_i};
      repeat (8) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the serial EEPROM command core.
// Assumes the host model frames every command and the checker is bound.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic wp_n;
    logic write_enable_cmd;
    logic [31:0] cmd;
    logic [5:0] nbits;
    logic busy;
    logic start;
    logic [15:0] addr;
    logic [2:0] kind;
    logic [1:0] bp;
    logic write_enable_latch;
  } sep_row_t;
  logic clk_sys_i, rstn_i, wp_n_i, sck, cs_n, si, so, so_oe, busy, write_enable_latch;
  logic bp_hi, bp_lo, pen, sleep, start, done, wr_vld;
  logic [7:0] nv_status_i, rx, wrd;
  logic [2:0] kind;
  logic [15:0] addr;
  int n_errors = 0;
  int comparisons = 0;
  int n_starts = 0;
  int n_wr = 0;
  int n0;
  sep_row_t row;
  sep_row_t rows [18] = '{
    '{'1, '1, 32'h42123400, 6'd24, '1, '1, 16'h1200, 3'h3, 2'h0, '0},
    '{'1, '1, 32'hd89abc00, 6'd24, '1, '1, 16'h8000, 3'h4, 2'h0, '0},
    '{'1, '1, 32'hc7000000, 6'd8, '1, '1, 16'h0000, 3'h5, 2'h0, '0},
    '{'1, '0, 32'h42123400, 6'd24, '0, '0, 16'h0000, 3'h0, 2'h0, '0},
    '{'1, '1, 32'h42120000, 6'd16, '0, '0, 16'h0000, 3'h0, 2'h0, '1},
    '{'1, '1, 32'h01040000, 6'd16, '1, '0, 16'h0000, 3'h0, 2'h1, '0},
    '{'1, '1, 32'h42c00000, 6'd24, '0, '0, 16'h0000, 3'h0, 2'h1, '0},
    '{'1, '1, 32'h42bfff00, 6'd24, '1, '1, 16'hbf80, 3'h3, 2'h1, '0},
    '{'1, '1, 32'hc7000000, 6'd8, '0, '0, 16'h0000, 3'h0, 2'h1, '0},
    '{'1, '1, 32'h01080000, 6'd16, '1, '0, 16'h0000, 3'h0, 2'h2, '0},
    '{'1, '1, 32'hd8800000, 6'd24, '0, '0, 16'h0000, 3'h0, 2'h2, '0},
    '{'1, '1, 32'hd87fff00, 6'd24, '1, '1, 16'h4000, 3'h4, 2'h2, '0},
    '{'1, '1, 32'h010c0000, 6'd16, '1, '0, 16'h0000, 3'h0, 2'h3, '0},
    '{'1, '1, 32'h42000000, 6'd24, '0, '0, 16'h0000, 3'h0, 2'h3, '0},
    '{'1, '1, 32'h01800000, 6'd16, '1, '0, 16'h0000, 3'h0, 2'h0, '0},
    '{'0, '1, 32'h018c0000, 6'd16, '0, '0, 16'h0000, 3'h0, 2'h0, '1},
    '{'0, '1, 32'h42123400, 6'd24, '1, '1, 16'h1200, 3'h3, 2'h0, '0},
    '{'1, '1, 32'h01000000, 6'd16, '1, '0, 16'h0000, 3'h0, 2'h0, '0}};
  ////////////////////////////////////////////////////////////////////////////
  sep_top #(.STATUS_WRITE_CYC(50), .PAGE_ERASE_CYC(60),
    .SECTOR_ERASE_CYC(80), .CHIP_ERASE_CYC(1000), .SIGNATURE(8'h3c)) sep_top_i (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .wp_n_i(wp_n_i), .nv_status_i(nv_status_i), .so_o(so), .so_oe_o(so_oe),
    .busy_flag_o(busy), .write_enable_latch_o(write_enable_latch), .block_protect_high_o(bp_hi),
    .block_protect_low_o(bp_lo), .protect_pin_enable_bit_o(pen), .deep_sleep_o(sleep),
    .op_start_o(start), .op_kind_o(kind), .op_addr_o(addr), .op_done_o(done),
    .wr_data_o(wrd), .wr_data_valid_o(wr_vld));
  sep_host_model sep_host_model_i (.clk_i(clk_sys_i), .so_i(so), .sck_o(sck), .cs_n_o(cs_n),
    .si_o(si), .rx_o(rx));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (start === 1'b1) n_starts++;
    if (wr_vld === 1'b1) n_wr++;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk_sys_i);
  endtask
  task automatic summarize();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn_i = 1'b0;
    wp_n_i = 1'b1;
    nv_status_i = 8'h00;
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    for (int r = 0; r < 18; r++) begin
      row = rows[r];
      wp_n_i <= row.wp_n;
      if (row.write_enable_cmd) sep_host_model_i.send(32'h06000000, 8);
      n0 = n_starts;
      sep_host_model_i.send(row.cmd, int'(row.nbits));
      check("busy", 32'(row.busy), 32'(busy));
      wait_idle();
      check("start", 32'(row.start), 32'(n_starts != n0));
      if (row.start) check("kind addr", 32'({row.kind, row.addr}), 32'({kind, addr}));
      check("protect", 32'(row.bp), 32'({bp_hi, bp_lo}));
      check("latch", 32'(row.write_enable_latch), 32'(write_enable_latch));
      $display("row %0d done", r);
    end
    sep_host_model_i.send(32'h06000000, 8);
    n0 = n_starts;
    sep_host_model_i.send(32'hc7000000, 8);
    sep_host_model_i.send(32'h06000000, 8);
    sep_host_model_i.send(32'h42123400, 24);
    wait_idle();
    check("starts while busy", 32'(n_starts - n0), 32'h1);
    check("latch after chip", 32'(write_enable_latch), 32'h0);
    $display("busy test done");
    sep_host_model_i.send(32'hb9000000, 8);
    repeat (310) @(posedge clk_sys_i);
    check("asleep", 32'(sleep), 32'h1);
    n0 = n_starts;
    sep_host_model_i.send(32'h06000000, 8);
    sep_host_model_i.send(32'hc7000000, 8);
    check("start in sleep", 32'(n_starts - n0), 32'h0);
    sep_host_model_i.send(32'hab000000, 32);
    check("signature", 32'(rx), 32'h3c);
    repeat (310) @(posedge clk_sys_i);
    check("awake", 32'(sleep), 32'h0);
    $display("sleep test done");
    sep_host_model_i.send(32'h06000000, 8);
    sep_host_model_i.send(32'hb9000000, 8);
    rstn_i <= 1'b0;
    nv_status_i <= 8'h8c;
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    check("power-up", 32'({sleep, write_enable_latch, so_oe, pen, bp_hi, bp_lo}), 32'h07);
    $display("reset test done");
    sep_host_model_i.send(32'h06000000, 8);
    sep_host_model_i.send(32'h01000000, 16);
    wait_idle();
    check("protect cleared", 32'({pen, bp_hi, bp_lo}), 32'h0);
    sep_host_model_i.send(32'h06000000, 8);
    n0 = n_starts;
    sep_host_model_i.send(32'h021234a5, 32);
    check("write start", 32'({busy, kind, addr}), 32'({1'b1, 3'h1, 16'h1234}));
    check("write launches", 32'(n_starts - n0), 32'h1);
    check("write data", 32'(wrd), 32'ha5);
    check("write bytes", 32'(n_wr), 32'h1);
    $display("write test done");
    summarize();
  end
endmodule
